// ==== shared/stall_thermal_pkg.sv ====
// Purpose: shared constants for the stall and thermal fault logic
// Assumes: 200 MHz hclk, AHB-Lite register access, 32-bit data
// Notes: register offsets are byte addresses, one word each
package stall_thermal_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_THRESH = 8'h04;
  localparam logic [7:0] ADDR_LOAD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // control_register_five fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_STUCK_REPORT_TO_PIN = 1;
  localparam int CTRL_LEARN = 2;
  localparam int CTRL_TMODE = 3;
  localparam int CTRL_TEMP_WARNING_TO_PIN = 4;
  localparam int CTRL_DECAY_LO = 5;
  localparam int CTRL_CLEAR = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] THRESH_RESET = 8'h00;
  localparam logic [2:0] DECAY_RIPPLE = 3'h7;

  // status fields
  localparam int ST_FAULT = 0;
  localparam int ST_STALL = 1;
  localparam int ST_SUMMARY = 2;
  localparam int ST_TEMP = 3;
  localparam int ST_OTS = 4;
  localparam int ST_HOT = 5;
  localparam int ST_COLD = 6;
  localparam int ST_LEARN_DONE = 7;
  localparam int ST_PIN = 8;

  // ****************************************
  // synchroniser lanes
  // ****************************************
  localparam int SY_SHUT = 0;
  localparam int SY_HOT = 1;
  localparam int SY_COLD = 2;
  localparam int SY_SLEEP = 3;
  localparam int SY_PIN = 4;
  localparam int SY_W = 5;
  localparam logic [4:0] SYNC_RESET = 5'h18;

  // ****************************************
  // timing and counts
  // ****************************************
  localparam int CLK_MHZ = 200;
  localparam int SLEEP_CLR_MIN_US = 18;
  localparam logic [11:0] SLEEP_CLR_MIN_CYC = 12'(SLEEP_CLR_MIN_US * CLK_MHZ);
  localparam int LOAD_UPDATE_NS = 100;
  localparam int LOAD_UPDATE_CYC = (LOAD_UPDATE_NS * CLK_MHZ) / 1000;
  localparam int AVG_DEPTH = 4;
  localparam logic [2:0] AVG_FULL = 3'h4;
  localparam int LEARN_ELEC_CYCLES = 16;
  localparam logic [5:0] LEARN_LAST = 6'(2 * LEARN_ELEC_CYCLES - 1);

  typedef enum logic [1:0] {LEARN_IDLE, LEARN_RUN, LEARN_DONE} learn_state_e;
endpackage : stall_thermal_pkg

// ==== logic/half_cycle_avg.sv ====
// Purpose: running average of the latest four half-cycle results
// Assumes: sample_valid is a one-cycle pulse on hclk
// Notes: avg_valid only once four samples are held since restart
`timescale 1ns/1ps
module half_cycle_avg
  import stall_thermal_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic restart,
  input wire logic sample_valid,
  input wire logic [7:0] sample,
  output logic [7:0] avg,
  output logic avg_valid
);
  logic [7:0] tap [AVG_DEPTH];
  logic [2:0] fill, next_fill;
  logic [7:0] next_avg;
  logic next_avg_valid;
  logic [9:0] sum;

  // ****************************************
  // tap line
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < AVG_DEPTH; i++) begin : g_tap
      logic [7:0] next_tap;
      // each tap takes its neighbour on a new sample
      always_comb begin
        next_tap = tap[i];
        if (sample_valid) begin
          next_tap = (i == 0) ? sample : tap[(i == 0) ? 0 : i - 1];
        end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          tap[i] <= 8'h00;
        end else begin
          tap[i] <= next_tap;
        end
      end
    end
  endgenerate

  // sum of the newest sample and the three held before it
  always_comb begin
    sum = {2'b00, sample};
    for (int k = 0; k < AVG_DEPTH - 1; k++) begin
      sum = sum + {2'b00, tap[k]};
    end
  end

  // ****************************************
  // result
  // ****************************************
  // fill count keeps a partial window from reporting a false low figure
  always_comb begin
    next_fill = fill;
    next_avg = avg;
    next_avg_valid = 1'b0;
    if (restart) begin
      next_fill = 3'h0;
    end else if (sample_valid) begin
      if (fill < AVG_FULL) begin
        next_fill = fill + 3'h1;
      end
      if (fill >= AVG_FULL - 3'h1) begin
        next_avg = sum[9:2];
        next_avg_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fill <= 3'h0;
      avg <= 8'h00;
      avg_valid <= 1'b0;
    end else begin
      fill <= next_fill;
      avg <= next_avg;
      avg_valid <= next_avg_valid;
    end
  end
endmodule : half_cycle_avg

// ==== logic/stall_and_thermal_fault_logic.sv ====
// Purpose: stall detection, stall learning and thermal fault flags
// Assumes: half-cycle results arrive on hclk; comparators are async pins
// Notes: fault pin is open drain, only ever pulled low
// Contract
// - stall detection only in ripple decay mode
// - stall detection needs enable bit set
// - eight-bit load figure readable by software
// - figure below threshold latches stall and fault
// - stall pulls fault pin only when reported
// - stall stays latched until clear or sleep pulse
// - figure averages four half-cycles, prompt update
// - figure holds for the next half-cycle
// - stall latched within two electrical cycles
// - threshold written by host or learned
// - learn sixteen cycles, load threshold, flag done
// - shutdown kills bridge, pump, pulls pin, latches
// - latched mode holds outputs off until clear
// - auto mode recovers, temperature flags stay latched
// - hot warning flags, self-clearing, keeps running
// - hot warning reaches pin when warning report set
// - cold warning flags, self-clearing, reportable
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module stall_and_thermal_fault_logic
  import stall_thermal_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic half_cycle_done,
  input wire logic [7:0] bemf_sample,
  input wire logic shutdown_temp,
  input wire logic hot_temp,
  input wire logic cold_temp,
  input wire logic sleep_pin_n,
  input wire logic fault_pin_n_in,
  output logic fault_pin_n_out,
  output logic fault_pin_n_oe,
  output logic bridge_enable,
  output logic charge_pump_enable
);
  // ****************************************
  // declarations
  // ****************************************
  logic [SY_W-1:0] sync1, sync2, pins;
  logic shut_s, hot_s, cold_s, sleep_s;
  logic wr_pend, next_wr_pend, rd_wait, next_rd_wait, in_map, next_in_map;
  logic [7:0] addr_q, next_addr_q;
  logic [31:0] next_hrdata, rd_word;
  logic accept;
  logic [7:0] ctrl, next_ctrl, thresh, next_thresh;
  logic host_clear;
  logic [11:0] sleep_cnt, next_sleep_cnt;
  logic sleep_clear, clear_req;
  logic [7:0] avg, load_figure, next_load_figure;
  logic avg_valid, ripple, stall_active, restart;
  learn_state_e learn_state, next_learn_state;
  logic [5:0] learn_cnt, next_learn_cnt;
  logic [7:0] learn_max, next_learn_max, learn_peak, learn_value;
  logic learn_load;
  logic stall_latched, next_stall_latched, stall_hit;
  logic ots_flag, next_ots_flag, thermal_off, next_thermal_off;
  logic global_fault, next_global_fault, pin_low, next_pin_low;
  logic warn_rep;

  // ****************************************
  // pin synchronisers
  // ****************************************
  assign pins = {fault_pin_n_in, sleep_pin_n, cold_temp, hot_temp, shutdown_temp};
  genvar g;
  generate
    for (g = 0; g < SY_W; g++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1[g] <= SYNC_RESET[g];
          sync2[g] <= SYNC_RESET[g];
        end else begin
          sync1[g] <= pins[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate
  assign shut_s = sync2[SY_SHUT];
  assign hot_s = sync2[SY_HOT];
  assign cold_s = sync2[SY_COLD];
  assign sleep_s = sync2[SY_SLEEP];

  // ****************************************
  // ahb-lite slave
  // ****************************************
  // reads take one wait state so a write just before is always seen
  assign accept = hsel && htrans[1] && hready;
  assign hreadyout = !rd_wait;
  assign hresp = 1'b0;

  always_comb begin
    next_wr_pend = accept && hwrite && (hsize == 3'h2);
    next_rd_wait = accept && !hwrite;
    next_addr_q = accept ? haddr[7:0] : addr_q;
    next_in_map = accept ? (haddr[31:8] == 24'h000000) : in_map;
    next_hrdata = rd_wait ? rd_word : hrdata;
  end

  // read mux, unmapped words read as zero
  always_comb begin
    rd_word = 32'h00000000;
    if (in_map) begin
      case (addr_q)
        ADDR_CTRL: rd_word[7:0] = ctrl;
        ADDR_THRESH: rd_word[7:0] = thresh;
        ADDR_LOAD: rd_word[7:0] = load_figure;
        ADDR_STATUS: begin
          rd_word[ST_FAULT] = global_fault;
          rd_word[ST_STALL] = stall_latched;
          rd_word[ST_SUMMARY] = stall_latched;
          rd_word[ST_TEMP] = ots_flag || hot_s || cold_s;
          rd_word[ST_OTS] = ots_flag;
          rd_word[ST_HOT] = hot_s;
          rd_word[ST_COLD] = cold_s;
          rd_word[ST_LEARN_DONE] = (learn_state == LEARN_DONE);
          rd_word[ST_PIN] = sync2[SY_PIN];
        end
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_wait <= 1'b0;
      addr_q <= 8'h00;
      in_map <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend <= next_wr_pend;
      rd_wait <= next_rd_wait;
      addr_q <= next_addr_q;
      in_map <= next_in_map;
      hrdata <= next_hrdata;
    end
  end

  // ****************************************
  // control and threshold registers
  // ****************************************
  // the learned value wins over a host write in the same cycle
  always_comb begin
    next_ctrl = ctrl;
    next_thresh = thresh;
    host_clear = 1'b0;
    if (wr_pend && in_map) begin
      case (addr_q)
        ADDR_CTRL: begin
          next_ctrl = hwdata[7:0];
          host_clear = hwdata[CTRL_CLEAR];
        end
        ADDR_THRESH: next_thresh = hwdata[7:0];
        default: next_thresh = thresh;
      endcase
    end
    if (learn_load) begin
      next_thresh = learn_value;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RESET;
      thresh <= THRESH_RESET;
    end else begin
      ctrl <= next_ctrl;
      thresh <= next_thresh;
    end
  end

  // ****************************************
  // sleep-pin clear pulse
  // ****************************************
  // any low stretch of at least the minimum width clears on release
  always_comb begin
    next_sleep_cnt = sleep_cnt;
    if (sleep_s) begin
      next_sleep_cnt = 12'h000;
    end else if (sleep_cnt < SLEEP_CLR_MIN_CYC) begin
      next_sleep_cnt = sleep_cnt + 12'h001;
    end
  end
  assign sleep_clear = sleep_s && (sleep_cnt == SLEEP_CLR_MIN_CYC);
  assign clear_req = host_clear || sleep_clear;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_cnt <= 12'h000;
    end else begin
      sleep_cnt <= next_sleep_cnt;
    end
  end

  // ****************************************
  // load figure
  // ****************************************
  assign ripple = (ctrl[CTRL_DECAY_LO+:3] == DECAY_RIPPLE);
  assign stall_active = ripple && ctrl[CTRL_EN];
  assign restart = !ripple;

  half_cycle_avg u_avg (
    .hclk(hclk),
    .hresetn(hresetn),
    .restart(restart),
    .sample_valid(half_cycle_done && ripple),
    .sample(bemf_sample),
    .avg(avg),
    .avg_valid(avg_valid)
  );

  // figure changes only on a new average, so it holds a half-cycle
  always_comb begin
    next_load_figure = avg_valid ? avg : load_figure;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_figure <= 8'h00;
    end else begin
      load_figure <= next_load_figure;
    end
  end

  // ****************************************
  // threshold learning
  // ****************************************
  // learned threshold sits one above the highest stalled figure
  assign learn_peak = (avg > learn_max) ? avg : learn_max;
  assign learn_value = (learn_peak == 8'hff) ? 8'hff : learn_peak + 8'h01;
  assign learn_load = (learn_state == LEARN_RUN) && avg_valid && (learn_cnt == LEARN_LAST);

  always_comb begin
    next_learn_state = learn_state;
    next_learn_cnt = learn_cnt;
    next_learn_max = learn_max;
    case (learn_state)
      LEARN_IDLE: begin
        next_learn_cnt = 6'h00;
        next_learn_max = 8'h00;
        if (ctrl[CTRL_LEARN] && ripple) begin
          next_learn_state = LEARN_RUN;
        end
      end
      LEARN_RUN: begin
        if (!ctrl[CTRL_LEARN] || !ripple) begin
          next_learn_state = LEARN_IDLE;
        end else if (avg_valid) begin
          next_learn_max = learn_peak;
          next_learn_cnt = learn_cnt + 6'h01;
          if (learn_load) begin
            next_learn_state = LEARN_DONE;
          end
        end
      end
      LEARN_DONE: begin
        if (!ctrl[CTRL_LEARN]) begin
          next_learn_state = LEARN_IDLE;
        end
      end
      default: next_learn_state = LEARN_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      learn_state <= LEARN_IDLE;
      learn_cnt <= 6'h00;
      learn_max <= 8'h00;
    end else begin
      learn_state <= next_learn_state;
      learn_cnt <= next_learn_cnt;
      learn_max <= next_learn_max;
    end
  end

  // ****************************************
  // fault flags and pin
  // ****************************************
  // a deliberate stall while learning must not latch a fault
  assign stall_hit = avg_valid && stall_active && (learn_state != LEARN_RUN)
                     && (avg < thresh);
  assign warn_rep = ctrl[CTRL_TEMP_WARNING_TO_PIN] && (hot_s || cold_s);

  // set wins over clear for every latched flag
  always_comb begin
    next_stall_latched = stall_hit || (stall_latched && !clear_req);
    next_ots_flag = shut_s || (ots_flag && !clear_req);
    next_thermal_off = thermal_off;
    if (shut_s) begin
      next_thermal_off = 1'b1;
    end else if (ctrl[CTRL_TMODE]) begin
      next_thermal_off = 1'b0;
    end else if (clear_req) begin
      next_thermal_off = 1'b0;
    end
    next_global_fault = next_stall_latched || next_thermal_off || warn_rep;
    next_pin_low = (next_stall_latched && ctrl[CTRL_STUCK_REPORT_TO_PIN])
                   || next_thermal_off || warn_rep;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stall_latched <= 1'b0;
      ots_flag <= 1'b0;
      thermal_off <= 1'b0;
      global_fault <= 1'b0;
      pin_low <= 1'b0;
    end else begin
      stall_latched <= next_stall_latched;
      ots_flag <= next_ots_flag;
      thermal_off <= next_thermal_off;
      global_fault <= next_global_fault;
      pin_low <= next_pin_low;
    end
  end

  // warnings never touch the bridge or the pump
  assign bridge_enable = !thermal_off;
  assign charge_pump_enable = !thermal_off;
  assign fault_pin_n_out = 1'b0;
  assign fault_pin_n_oe = pin_low;

  // ****************************************
  // checks
  // ****************************************
  property p_ripple_only;
    @(posedge hclk) disable iff (!hresetn) $rose(stall_latched) |-> $past(ripple);
  endproperty
  a_ripple_only: assert property (p_ripple_only) else $error("stall outside ripple");

  property p_enable_needed;
    @(posedge hclk) disable iff (!hresetn)
      !ctrl[CTRL_EN] && !stall_latched |=> !stall_latched;
  endproperty
  a_enable_needed: assert property (p_enable_needed) else $error("stall while off");

  property p_stall_latch;
    @(posedge hclk) disable iff (!hresetn) stall_hit |=> stall_latched && global_fault;
  endproperty
  a_stall_latch: assert property (p_stall_latch) else $error("stall not latched");

  property p_stall_pin;
    @(posedge hclk) disable iff (!hresetn)
      stall_latched && ctrl[CTRL_STUCK_REPORT_TO_PIN] && $past(ctrl[CTRL_STUCK_REPORT_TO_PIN]) |-> fault_pin_n_oe;
  endproperty
  a_stall_pin: assert property (p_stall_pin) else $error("stall pin missing");

  property p_stall_hold;
    @(posedge hclk) disable iff (!hresetn) stall_latched && !clear_req |=> stall_latched;
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall dropped");

  property p_figure_update;
    @(posedge hclk) disable iff (!hresetn)
      avg_valid |=> load_figure == $past(avg) ##1 ($past(avg_valid) || $stable(load_figure));
  endproperty
  a_figure_update: assert property (p_figure_update) else $error("figure update");

  property p_figure_hold;
    @(posedge hclk) disable iff (!hresetn) !avg_valid |=> $stable(load_figure);
  endproperty
  a_figure_hold: assert property (p_figure_hold) else $error("figure moved");

  property p_learn_done;
    @(posedge hclk) disable iff (!hresetn)
      learn_load |=> learn_state == LEARN_DONE && thresh == $past(learn_value);
  endproperty
  a_learn_done: assert property (p_learn_done) else $error("learn not loaded");

  property p_shutdown;
    @(posedge hclk) disable iff (!hresetn)
      shut_s |=> !bridge_enable && !charge_pump_enable && fault_pin_n_oe && ots_flag;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown response");

  property p_latched_mode;
    @(posedge hclk) disable iff (!hresetn)
      thermal_off && !ctrl[CTRL_TMODE] && !clear_req |=> thermal_off;
  endproperty
  a_latched_mode: assert property (p_latched_mode) else $error("latched released");

  property p_auto_mode;
    @(posedge hclk) disable iff (!hresetn)
      thermal_off && ctrl[CTRL_TMODE] && !shut_s && !stall_latched && !stall_hit && !warn_rep
      && ots_flag && !clear_req |=> !thermal_off && !global_fault && !fault_pin_n_oe && ots_flag;
  endproperty
  a_auto_mode: assert property (p_auto_mode) else $error("auto recovery");

  property p_warn_pin;
    @(posedge hclk) disable iff (!hresetn)
      hot_s && ctrl[CTRL_TEMP_WARNING_TO_PIN] |=> fault_pin_n_oe && global_fault;
  endproperty
  a_warn_pin: assert property (p_warn_pin) else $error("warning pin missing");
endmodule : stall_and_thermal_fault_logic

// ==== dv/host_pins.sv ====
// Purpose: host side of the fault and sleep pins
// Assumes: fault pin has a pull-up, sleep pin is driven by the host
// Notes: reset pulse length fixed at 4000 cycles, 20 us at 200 MHz
`timescale 1ns/1ps
module host_pins (
  input wire logic hclk,
  input wire logic fault_pin_n_out,
  input wire logic fault_pin_n_oe,
  output logic fault_pin_n,
  output logic sleep_pin_n
);
  // ****************************************
  // pin model
  // ****************************************
  // pull-up wins whenever the device lets go of the line
  assign fault_pin_n = fault_pin_n_oe ? fault_pin_n_out : 1'b1;

  // awake from time zero
  initial sleep_pin_n = 1'b1;

  // short low pulse: clears faults, too long would put the part to sleep
  task automatic sleep_pulse();
    @(posedge hclk);
    sleep_pin_n <= 1'b0;
    repeat (4000) @(posedge hclk);
    sleep_pin_n <= 1'b1;
  endtask : sleep_pulse
endmodule : host_pins

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the stall and thermal fault logic
// Assumes: AHB-Lite single word transfers, hready tied to hreadyout
// Notes: fixed stimulus only; temperature pins need 3 edges to land
`timescale 1ns/1ps
module tb
  import stall_thermal_pkg::*;
;
  localparam logic [31:0] EN = 32'h1 << CTRL_EN, RP = 32'h1 << CTRL_STUCK_REPORT_TO_PIN,
    LR = 32'h1 << CTRL_LEARN, TM = 32'h1 << CTRL_TMODE, TW = 32'h1 << CTRL_TEMP_WARNING_TO_PIN,
    CL = 32'h1 << CTRL_CLEAR, RIP = 32'(DECAY_RIPPLE) << CTRL_DECAY_LO;
  localparam logic [31:0] SF = 32'h1 << ST_FAULT, SS = 32'h1 << ST_STALL,
    SU = 32'h1 << ST_SUMMARY, ST = 32'h1 << ST_TEMP, SO = 32'h1 << ST_OTS,
    SH = 32'h1 << ST_HOT, SC = 32'h1 << ST_COLD, SL = 32'h1 << ST_LEARN_DONE,
    SP = 32'h1 << ST_PIN;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, half_cycle_done;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] bemf_sample;
  logic shutdown_temp, hot_temp, cold_temp, sleep_pin_n, fault_pin_n;
  logic fault_pin_n_out, fault_pin_n_oe, bridge_enable, charge_pump_enable;
  int err_count = 0;
  int n_checks = 0;

  // ****************************************
  // clock, design and host pins
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  stall_and_thermal_fault_logic i_stall_and_thermal_fault_logic (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .half_cycle_done,
    .bemf_sample, .shutdown_temp, .hot_temp, .cold_temp, .sleep_pin_n,
    .fault_pin_n_in(fault_pin_n), .fault_pin_n_out, .fault_pin_n_oe,
    .bridge_enable, .charge_pump_enable
  );

  host_pins i_host_pins (
    .hclk, .fault_pin_n_out, .fault_pin_n_oe, .fault_pin_n, .sleep_pin_n
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // bounded wait for hready; a hang counts as a mismatch
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      err_count++;
      print_verdict();
    end
  endtask : wait_rdy

  // one single word transfer; read data taken at the final ready edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hffffffff);
    xfer(1'b0, a, 32'h0);
    chk(rd & m, e);
    // slave never signals an error response
    chk({31'h0, hresp}, 32'h0);
  endtask : rchk

  // pins: global fault pull-down and bridge enable
  task automatic pins(input logic oe, input logic br);
    chk({31'h0, fault_pin_n_oe}, {31'h0, oe});
    chk({30'h0, bridge_enable, charge_pump_enable}, {30'h0, br, br});
  endtask : pins

  task automatic hc(input logic [7:0] v, input int n);
    repeat (n) begin
      @(posedge hclk);
      half_cycle_done <= 1'b1;
      bemf_sample <= v;
      @(posedge hclk);
      half_cycle_done <= 1'b0;
    end
    repeat (4) @(posedge hclk);
  endtask : hc

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    half_cycle_done = 1'b0;
    bemf_sample = 8'h0;
    shutdown_temp = 1'b0;
    hot_temp = 1'b0;
    cold_temp = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(ADDR_CTRL, 32'h0);
    rchk(ADDR_THRESH, 32'h0);
    xfer(1'b1, ADDR_THRESH, 32'h40);
    rchk(ADDR_THRESH, 32'h40);
    rchk(8'h10, 32'h0);
    rchk(ADDR_STATUS, SP, 32'h1ff);
    $display("test registers done");
    // stall logic ignores samples outside ripple decay
    xfer(1'b1, ADDR_CTRL, EN | RP);
    hc(8'h10, 4);
    rchk(ADDR_STATUS, 32'h0, 32'hff);
    xfer(1'b1, ADDR_CTRL, EN | RP | RIP);
    hc(8'h08, 1);
    hc(8'h10, 1);
    hc(8'h18, 1);
    rchk(ADDR_STATUS, 32'h0, 32'hff);
    hc(8'h20, 1);
    pins(1'b1, 1'b1);
    rchk(ADDR_LOAD, 32'h14);
    rchk(ADDR_STATUS, SF | SS | SU, 32'h1ff);
    xfer(1'b1, ADDR_LOAD, 32'h55);
    rchk(ADDR_LOAD, 32'h14);
    hc(8'hf0, 1);
    rchk(ADDR_LOAD, 32'h4e);
    rchk(ADDR_STATUS, SF | SS | SU, 32'hff);
    xfer(1'b1, ADDR_CTRL, EN | RP | RIP | CL);
    rchk(ADDR_CTRL, EN | RP | RIP);
    rchk(ADDR_STATUS, 32'h0, 32'hff);
    pins(1'b0, 1'b1);
    xfer(1'b1, ADDR_CTRL, EN | RIP);
    hc(8'h01, 4);
    pins(1'b0, 1'b1);
    rchk(ADDR_STATUS, SF | SS | SU | SP, 32'h1ff);
    i_host_pins.sleep_pulse();
    repeat (8) @(posedge hclk);
    rchk(ADDR_STATUS, 32'h0, 32'hff);
    xfer(1'b1, ADDR_CTRL, RP | RIP);
    hc(8'h01, 4);
    rchk(ADDR_STATUS, 32'h0, 32'hff);
    $display("test stall done");
    // latched thermal shutdown, then automatic recovery
    shutdown_temp <= 1'b1;
    repeat (6) @(posedge hclk);
    pins(1'b1, 1'b0);
    rchk(ADDR_STATUS, SF | ST | SO, 32'hff);
    shutdown_temp <= 1'b0;
    repeat (6) @(posedge hclk);
    pins(1'b1, 1'b0);
    xfer(1'b1, ADDR_CTRL, TM | CL);
    repeat (4) @(posedge hclk);
    pins(1'b0, 1'b1);
    shutdown_temp <= 1'b1;
    repeat (6) @(posedge hclk);
    pins(1'b1, 1'b0);
    shutdown_temp <= 1'b0;
    repeat (6) @(posedge hclk);
    pins(1'b0, 1'b1);
    rchk(ADDR_STATUS, ST | SO, 32'hff);
    xfer(1'b1, ADDR_CTRL, CL);
    rchk(ADDR_STATUS, 32'h0, 32'hff);
    $display("test thermal done");
    // hot and cold warnings, with and without pin report
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, ADDR_CTRL, k[0] ? TW : 32'h0);
      if (k[1]) begin
        cold_temp <= 1'b1;
      end else begin
        hot_temp <= 1'b1;
      end
      repeat (6) @(posedge hclk);
      pins(k[0], 1'b1);
      rchk(ADDR_STATUS, (k[0] ? SF : 32'h0) | ST | (k[1] ? SC : SH), 32'hff);
      hot_temp <= 1'b0;
      cold_temp <= 1'b0;
      repeat (6) @(posedge hclk);
      pins(1'b0, 1'b1);
      rchk(ADDR_STATUS, 32'h0, 32'hff);
    end
    $display("test warnings done");
    // host learns the threshold during a deliberate stall
    xfer(1'b1, ADDR_CTRL, EN | LR | RIP);
    // three fill samples, then 32 averages finish the learning
    hc(8'h20, 35);
    rchk(ADDR_STATUS, SL, 32'hff);
    rchk(ADDR_THRESH, 32'h21);
    // still stalled: the learned threshold must now catch it
    hc(8'h20, 1);
    rchk(ADDR_STATUS, SF | SS | SU | SL, 32'hff);
    $display("test learning done");
    print_verdict();
  end
endmodule : tb
